// >>> logic/sar_adc_params.svh
// Offsets, field positions, reset values and timing counts of the converter control block.
// Assumes the includer is the converter control module and its package.
// Notes on behaviour
// - Successive approximation turns the held sample into an 8-bit result.
// - Reference comes from the analog supply or the reference-capable pin, per pin roles.
// - Sleep conversions only run on the internal RC clock; software must select it.
// - Clock select 00, 01, 10, 11 give osc/2, osc/8, osc/32, internal RC.
// - Channel select codes 000 to 100 pick analog inputs 0 to 4.
// - With power on, writing one to the status bit starts; it reads one meanwhile.
// - Hardware clears the status bit when a conversion finishes.
// - Pin role field sets analog pins and the external reference choice.
// - Bits 7 to 3 of the pin role register read as zero.
// - Completion loads the result, clears the status bit and sets the done flag together.
// - After completion the capacitor stays disconnected two bit periods before acquiring.
// - The holding capacitor is never discharged between conversions.
// - Each result bit takes one period of the selected conversion clock.
// - A whole conversion takes nine and a half conversion clock periods.
// - Clearing the status bit aborts, keeps the old result, waits two periods, reacquires.
// - Port reads return zero on every pin configured as analog input.
`ifndef SAR_ADC_PARAMS_SVH
`define SAR_ADC_PARAMS_SVH

`define ADC_IDX_CTRL       10'h01f
`define ADC_IDX_PINCFG     10'h09f
`define ADC_IDX_RESULT     10'h01e
`define ADC_IDX_STATUS     10'h020
`define ADC_CTRL_RESET     8'h00
`define ADC_PINCFG_RESET   3'h0
`define ADC_RESULT_RESET   8'h00
`define ADC_GO_BIT         2
`define ADC_FLAG_BIT       0
`define ADC_HALF_DIV2      4'h0
`define ADC_HALF_DIV8      4'h3
`define ADC_HALF_DIV32     4'hf
`define ADC_CONV_HALVES    5'h13
`define ADC_HOLD_HALVES    5'h04
`define ADC_FIRST_DECISION 5'h02
`define ADC_SLVERR_NONE    1'b0

`endif

// >>> logic/sar_adc_pkg.sv
// Types shared by the converter control block.
// Assumes the constants header is compiled alongside.
`default_nettype none
package sar_adc_pkg;

	typedef enum logic [1:0] {
		CLK_OSC2  = 2'h0,
		CLK_OSC8  = 2'h1,
		CLK_OSC32 = 2'h2,
		CLK_RC    = 2'h3
	} clk_sel_t;

	typedef struct packed {
		clk_sel_t   conv_clock_select;
		logic [2:0] input_channel_select;
		logic       go;
		logic       reserved;
		logic       converter_power_on;
	} ctrl_t;

	typedef enum logic [1:0] {
		ST_ACQUIRE = 2'h0,
		ST_CONVERT = 2'h1,
		ST_HOLDOFF = 2'h3
	} conv_state_t;

	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_CTRL,
		SEL_PINCFG,
		SEL_RESULT,
		SEL_STATUS
	} reg_sel_t;

endpackage : sar_adc_pkg
`default_nettype wire

// >>> logic/sar_adc_control.sv
// Converter control: APB register file, conversion clock, SAR sequencer and pin roles.
// Assumes APB inputs and all pin inputs are synchronous to pclk.
`include "sar_adc_params.svh"
`default_nettype none
module sar_adc_control (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        comparator_high,
	input  wire logic        internal_rc_tick,
	input  wire logic        sleep_active,
	input  wire logic [4:0]  port_pins_in,
	output logic      [7:0]  dac_code,
	output logic      [2:0]  input_channel_select,
	output logic             holding_cap_connect,
	output logic             external_ref_select,
	output logic      [4:0]  analog_pin_mask,
	output logic      [4:0]  port_read_value,
	output logic             conversion_done_flag
);

	////////////////////////////////////////////////////////////////////////////////
	function automatic sar_adc_pkg::reg_sel_t reg_decode(input logic [11:0] addr);
		if (addr[1:0] != 2'h0)
			return sar_adc_pkg::SEL_NONE;
		case (addr[11:2])
			`ADC_IDX_CTRL:   return sar_adc_pkg::SEL_CTRL;
			`ADC_IDX_PINCFG: return sar_adc_pkg::SEL_PINCFG;
			`ADC_IDX_RESULT: return sar_adc_pkg::SEL_RESULT;
			`ADC_IDX_STATUS: return sar_adc_pkg::SEL_STATUS;
			default:         return sar_adc_pkg::SEL_NONE;
		endcase
	endfunction : reg_decode

	// Mask bit n set means channel n is an analog input; bit 5 asks for the external reference.
	function automatic logic [5:0] pin_roles(input logic [2:0] cfg);
		case (cfg)
			3'h0, 3'h2: return 6'h1f;
			3'h1, 3'h3: return 6'h37;
			3'h4:       return 6'h0b;
			default:    return 6'h00;
		endcase
	endfunction : pin_roles

	////////////////////////////////////////////////////////////////////////////////
	sar_adc_pkg::ctrl_t       ctrl, next_ctrl;
	sar_adc_pkg::conv_state_t state, next_state;
	logic [2:0]  pin_role_select, next_pin_role_select;
	logic [7:0]  conversion_result, next_conversion_result;
	logic        next_flag;
	logic [7:0]  sar, next_sar;
	logic [7:0]  trial, next_trial;
	logic [4:0]  half_cnt, next_half_cnt;
	logic [3:0]  div_cnt, next_div_cnt;
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;
	logic [7:0]  next_dac_code;
	logic [5:0]  roles;
	logic        half_tick;
	logic [3:0]  div_limit;
	logic        wr_fire;
	logic        rd_sample;
	sar_adc_pkg::reg_sel_t sel;

	always_comb begin
		sel       = reg_decode(paddr);
		rd_sample = psel && penable && !pready;
		wr_fire   = psel && penable && pready && pwrite;
		roles     = pin_roles(pin_role_select);
		case (ctrl.conv_clock_select)
			sar_adc_pkg::CLK_OSC2:  div_limit = `ADC_HALF_DIV2;
			sar_adc_pkg::CLK_OSC8:  div_limit = `ADC_HALF_DIV8;
			default:                div_limit = `ADC_HALF_DIV32;
		endcase
		// Oscillator-derived clocks stop in sleep, so only the RC source keeps ticking.
		if (ctrl.conv_clock_select == sar_adc_pkg::CLK_RC)
			half_tick = internal_rc_tick;
		else
			half_tick = !sleep_active && (div_cnt >= div_limit);
	end

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_ctrl              = ctrl;
		next_pin_role_select   = pin_role_select;
		next_conversion_result = conversion_result;
		next_flag              = conversion_done_flag;
		next_state             = state;
		next_sar               = sar;
		next_trial             = trial;
		next_half_cnt          = half_cnt;
		next_div_cnt           = div_cnt;
		next_prdata            = 32'h0000_0000;
		next_pready            = rd_sample;
		next_pslverr           = `ADC_SLVERR_NONE;

		// A greater-or-equal compare lets a smaller divider take over mid-bit without a hang.
		if (state == sar_adc_pkg::ST_ACQUIRE || half_tick)
			next_div_cnt = 4'h0;
		else
			next_div_cnt = div_cnt + 4'h1;

		if (rd_sample) begin
			next_pslverr = (sel == sar_adc_pkg::SEL_NONE);
			case (sel)
				sar_adc_pkg::SEL_CTRL:   next_prdata = {24'h00_0000, ctrl};
				sar_adc_pkg::SEL_PINCFG: next_prdata = {29'h0, pin_role_select};
				sar_adc_pkg::SEL_RESULT: next_prdata = {24'h00_0000, conversion_result};
				sar_adc_pkg::SEL_STATUS: next_prdata = {31'h0, conversion_done_flag};
				default:                 next_prdata = 32'h0000_0000;
			endcase
		end

		if (wr_fire) begin
			case (sel)
				sar_adc_pkg::SEL_CTRL: begin
					next_ctrl = sar_adc_pkg::ctrl_t'(pwdata[7:0]);
					// A start request while powered down is dropped.
					if (!pwdata[0])
						next_ctrl.go = 1'b0;
				end
				sar_adc_pkg::SEL_PINCFG: next_pin_role_select = pwdata[2:0];
				sar_adc_pkg::SEL_RESULT: next_conversion_result = pwdata[7:0];
				sar_adc_pkg::SEL_STATUS: next_flag = pwdata[`ADC_FLAG_BIT];
				default: ;
			endcase
		end

		case (state)
			sar_adc_pkg::ST_ACQUIRE: begin
				// Acquisition timing is software's job; the start is taken as soon as seen.
				if (ctrl.go && ctrl.converter_power_on) begin
					next_state    = sar_adc_pkg::ST_CONVERT;
					next_sar      = 8'h00;
					next_trial    = 8'h80;
					next_half_cnt = 5'h00;
				end
			end
			sar_adc_pkg::ST_CONVERT: begin
				if (!next_ctrl.go || !next_ctrl.converter_power_on) begin
					// Abort keeps the previous result and still observes the holdoff.
					next_state    = sar_adc_pkg::ST_HOLDOFF;
					next_half_cnt = 5'h00;
					next_ctrl.go  = 1'b0;
				end else if (half_tick) begin
					next_half_cnt = half_cnt + 5'h01;
					// One decision per bit period, MSB first.
					if (half_cnt >= `ADC_FIRST_DECISION && !half_cnt[0] && trial != 8'h00) begin
						if (comparator_high)
							next_sar = sar | trial;
						next_trial = trial >> 1;
					end
					// Nineteen half periods make the full conversion.
					if (half_cnt == `ADC_CONV_HALVES - 5'h01) begin
						next_conversion_result = sar;
						next_ctrl.go           = 1'b0;
						next_flag              = 1'b1;
						next_state             = sar_adc_pkg::ST_HOLDOFF;
						next_half_cnt          = 5'h00;
					end
				end
			end
			sar_adc_pkg::ST_HOLDOFF: begin
				// Capacitor stays off the channel for two bit periods.
				if (half_tick)
					next_half_cnt = half_cnt + 5'h01;
				if (half_tick && half_cnt == `ADC_HOLD_HALVES - 5'h01)
					next_state = sar_adc_pkg::ST_ACQUIRE;
			end
			default: next_state = sar_adc_pkg::ST_ACQUIRE;
		endcase

		next_dac_code = next_sar | next_trial;
	end

	////////////////////////////////////////////////////////////////////////////////
	// The capacitor is only switched, never shorted, so its charge carries over.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl                 <= sar_adc_pkg::ctrl_t'(`ADC_CTRL_RESET);
			pin_role_select      <= `ADC_PINCFG_RESET;
			conversion_result    <= `ADC_RESULT_RESET;
			conversion_done_flag <= 1'b0;
			state                <= sar_adc_pkg::ST_ACQUIRE;
			sar                  <= 8'h00;
			trial                <= 8'h00;
			half_cnt             <= 5'h00;
			div_cnt              <= 4'h0;
			prdata               <= 32'h0000_0000;
			pready               <= 1'b0;
			pslverr              <= 1'b0;
			dac_code             <= 8'h00;
			input_channel_select <= 3'h0;
			holding_cap_connect  <= 1'b0;
			external_ref_select  <= 1'b0;
			analog_pin_mask      <= 5'h00;
			port_read_value      <= 5'h00;
		end else begin
			ctrl                 <= next_ctrl;
			pin_role_select      <= next_pin_role_select;
			conversion_result    <= next_conversion_result;
			conversion_done_flag <= next_flag;
			state                <= next_state;
			sar                  <= next_sar;
			trial                <= next_trial;
			half_cnt             <= next_half_cnt;
			div_cnt              <= next_div_cnt;
			prdata               <= next_prdata;
			pready               <= next_pready;
			pslverr              <= next_pslverr;
			dac_code             <= next_dac_code;
			input_channel_select <= next_ctrl.input_channel_select;
			holding_cap_connect  <= next_ctrl.converter_power_on
			                        && next_state == sar_adc_pkg::ST_ACQUIRE;
			external_ref_select  <= roles[5];
			analog_pin_mask      <= roles[4:0];
			port_read_value      <= port_pins_in & ~roles[4:0];
		end
	end

endmodule : sar_adc_control
`default_nettype wire

// >>> logic/unused_placeholder_none.sv
`default_nettype none
`default_nettype wire

// >>> bench/sar_adc_monitor.sv
// Port checks of the converter control block.
// Assumes writes to one register are at least three cycles apart.
`default_nettype none
module sar_adc_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [4:0]  port_pins_in,
	input wire logic [2:0]  input_channel_select,
	input wire logic        holding_cap_connect,
	input wire logic        external_ref_select,
	input wire logic [4:0]  analog_pin_mask,
	input wire logic [4:0]  port_read_value,
	input wire logic        conversion_done_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic       wr, on, next_on;
	logic [2:0] code, ch, next_code, next_ch;
	logic [4:0] low, next_low;
	assign wr = psel && penable && pready && pwrite && !pslverr;
	always_comb begin
		next_on   = (wr && paddr == 12'h07c) ? pwdata[0] : on;
		next_ch   = (wr && paddr == 12'h07c) ? pwdata[5:3] : ch;
		next_code = (wr && paddr == 12'h27c) ? pwdata[2:0] : code;
		next_low  = holding_cap_connect ? 5'h00 : low + {4'h0, low != 5'h1f};
	end
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) {on, ch, code, low} <= '0;
		else {on, ch, code, low} <= {next_on, next_ch, next_code, next_low};
	////////////////////////////////////////////////////////////////////////
	sequence s_ctrl_wr;
		wr && paddr == 12'h07c;
	endsequence
	sequence s_pin_wr;
		wr && paddr == 12'h27c;
	endsequence
	sequence s_start;
		s_ctrl_wr ##0 (pwdata[2] && pwdata[0] && holding_cap_connect);
	endsequence
	a_ref_follows: assert property (s_pin_wr |-> ##2
		external_ref_select == (!code[2] && code[0])) else $error("reference select wrong");
	a_mask_follows: assert property (s_pin_wr |-> ##2 analog_pin_mask ==
		(!code[2] ? (code[0] ? 5'h17 : 5'h1f) : code == 3'h4 ? 5'h0b : 5'h00))
		else $error("pin mask wrong");
	a_channel_copy: assert property (s_ctrl_wr |-> ##2 input_channel_select == ch)
		else $error("channel copy wrong");
	a_port_masked: assert property ($past(presetn) |-> port_read_value ==
		($past(port_pins_in) & ~analog_pin_mask)) else $error("port read not masked");
	a_hold_after: assert property ($rose(conversion_done_flag) |-> !holding_cap_connect [*4])
		else $error("capacitor reconnected early");
	a_done_length: assert property ($rose(conversion_done_flag) |-> low >= 5'h10)
		else $error("conversion too short");
	a_start_drops: assert property (s_start |-> ##[1:3] !holding_cap_connect)
		else $error("start ignored");
	a_off_no_flag: assert property (!on && !conversion_done_flag && !(wr && paddr == 12'h080)
		|=> !conversion_done_flag) else $error("flag raised while off");
endmodule : sar_adc_monitor
bind sar_adc_control sar_adc_monitor monitor (
	.pclk                 (pclk),
	.presetn              (presetn),
	.psel                 (psel),
	.penable              (penable),
	.pwrite               (pwrite),
	.paddr                (paddr),
	.pwdata               (pwdata),
	.pready               (pready),
	.pslverr              (pslverr),
	.port_pins_in         (port_pins_in),
	.input_channel_select (input_channel_select),
	.holding_cap_connect  (holding_cap_connect),
	.external_ref_select  (external_ref_select),
	.analog_pin_mask      (analog_pin_mask),
	.port_read_value      (port_read_value),
	.conversion_done_flag (conversion_done_flag)
);
`default_nettype wire

// >>> bench/analog_source.sv
// Analog inputs with fixed levels and the sampler's holding capacitor.
// Assumes the comparator is high when the held level is not below the trial code.
`default_nettype none
module analog_source #(
	parameter logic [39:0] LEVELS = 40'h0
) (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic [7:0] dac_code,
	input wire logic [2:0] input_channel_select,
	input wire logic       holding_cap_connect,
	output logic           comparator_high
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] held;
	// Charge is refreshed only while connected, so it survives between conversions.
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) held <= 8'h00;
		else if (holding_cap_connect) held <= LEVELS[input_channel_select * 8 +: 8];
	assign comparator_high = held >= dac_code;
endmodule : analog_source
`default_nettype wire

// >>> bench/sar_adc_control_test.sv
// Self-checking bench: APB register sequences against the converter control block.
// Assumes a 25 MHz pclk and an internal RC half tick every eight cycles.
`default_nettype none
module sar_adc_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [39:0] LEVELS = 40'h80ffa55a00;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, comparator_high, e;
	logic        internal_rc_tick, sleep_active, holding_cap_connect, external_ref_select;
	logic        conversion_done_flag;
	logic [2:0]  input_channel_select, rc_div;
	logic [4:0]  port_pins_in, analog_pin_mask, port_read_value;
	logic [7:0]  dac_code;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	int          mismatches, checks_done, cycles, n, h;
	sar_adc_control dut (
		.pclk                 (pclk),
		.presetn              (presetn),
		.psel                 (psel),
		.penable              (penable),
		.pwrite               (pwrite),
		.paddr                (paddr),
		.pwdata               (pwdata),
		.prdata               (prdata),
		.pready               (pready),
		.pslverr              (pslverr),
		.comparator_high      (comparator_high),
		.internal_rc_tick     (internal_rc_tick),
		.sleep_active         (sleep_active),
		.port_pins_in         (port_pins_in),
		.dac_code             (dac_code),
		.input_channel_select (input_channel_select),
		.holding_cap_connect  (holding_cap_connect),
		.external_ref_select  (external_ref_select),
		.analog_pin_mask      (analog_pin_mask),
		.port_read_value      (port_read_value),
		.conversion_done_flag (conversion_done_flag)
	);
	analog_source #(.LEVELS(LEVELS)) src (
		.pclk                 (pclk),
		.presetn              (presetn),
		.dac_code             (dac_code),
		.input_channel_select (input_channel_select),
		.holding_cap_connect  (holding_cap_connect),
		.comparator_high      (comparator_high)
	);
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		rc_div <= presetn ? rc_div + 3'h1 : 3'h0;
		internal_rc_tick <= presetn && rc_div == 3'h7;
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			mismatches++;
			final_report();
		end
	end
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : final_report
	task automatic check(input string s, input logic [31:0] x, input logic [31:0] g);
		checks_done++;
		if (g !== x) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", s, x, g);
		end
	endtask : check
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wait_flag;
		n = 0;
		while (conversion_done_flag !== 1'b1 && n < 1000) begin
			@(posedge pclk);
			n++;
		end
	endtask : wait_flag
	task automatic rd(input logic [11:0] a, input logic [31:0] x, input string s);
		apb(1'b0, a, 32'h0);
		check(s, x, q);
	endtask : rd
	////////////////////////////////////////////////////////////////////////
	initial begin
		{presetn, psel, penable, pwrite, sleep_active} = '0;
		{paddr, pwdata} = '0;
		port_pins_in = 5'h1f;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h07c, 32'h0, "control");
		rd(12'h27c, 32'h0, "pin roles");
		rd(12'h078, 32'h0, "result");
		rd(12'h080, 32'h0, "flag");
		apb(1'b0, 12'h100, 32'h0);
		check("unmapped", 32'h1, {31'h0, e});
		check("unmapped data", 32'h0, q);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, 12'h27c, 32'hf8 | i);
			rd(12'h27c, i, "pin roles");
			check("ext ref", i == 1 || i == 3, {31'h0, external_ref_select});
			q = (i == 1 || i == 3) ? 32'h08 : i[2] ? (i == 4 ? 32'h14 : 32'h1f) : 32'h0;
			check("port", q, {27'h0, port_read_value});
		end
		apb(1'b1, 12'h27c, 32'h0);
		$display("test pin roles done");
		// Each pass uses another channel; passes 0 to 3 each use another clock source and pass 4 repeats osc/2; pass 3 runs asleep on RC.
		for (int i = 0; i < 5; i++) begin
			h = (i == 3) ? 8 : (i == 1) ? 4 : (i == 2) ? 16 : 1;
			sleep_active <= (i == 3);
			apb(1'b1, 12'h07c, {i[1:0], i[2:0], 3'h1});
			repeat (30) @(posedge pclk);
			apb(1'b1, 12'h080, 32'h0);
			apb(1'b1, 12'h07c, {i[1:0], i[2:0], 3'h5});
			wait_flag();
			check("time", 1, n >= 18 * h - 3 && n <= 20 * h + 3);
			rd(12'h078, LEVELS[i * 8 +: 8], "result");
			rd(12'h07c, {i[1:0], i[2:0], 3'h1}, "go");
			rd(12'h080, 32'h1, "flag");
		end
		sleep_active <= 1'b0;
		$display("test conversions done");
		apb(1'b1, 12'h080, 32'h0);
		apb(1'b1, 12'h07c, 32'h89);
		repeat (30) @(posedge pclk);
		apb(1'b1, 12'h07c, 32'h8d);
		repeat (100) @(posedge pclk);
		apb(1'b1, 12'h07c, 32'h0d);
		wait_flag();
		check("switch time", 1, n <= 23);
		rd(12'h078, 32'h5a, "switched result");
		rd(12'h07c, 32'h09, "switched control");
		$display("test clock switch done");
		apb(1'b1, 12'h080, 32'h0);
		apb(1'b1, 12'h07c, 32'h8d);
		repeat (100) @(posedge pclk);
		apb(1'b1, 12'h07c, 32'h89);
		repeat (200) @(posedge pclk);
		check("reacquire", 1, {31'h0, holding_cap_connect});
		rd(12'h078, 32'h5a, "kept");
		rd(12'h080, 32'h0, "no flag");
		apb(1'b1, 12'h07c, 32'h04);
		repeat (100) @(posedge pclk);
		rd(12'h07c, 32'h0, "go off");
		rd(12'h080, 32'h0, "flag off");
		$display("test abort done");
		final_report();
	end
endmodule : sar_adc_control_test
`default_nettype wire
